// ===== hdl/ts_out_consts.vh
/*
 * constants for the time-stamped output scheduler: process-image offsets,
 * entry layout, status codes and the microsecond divider.
 * assumes a 50 MHz clock and a byte-wide process-image port.
 */
`ifndef TS_OUT_CONSTS_VH
`define TS_OUT_CONSTS_VH

// ------------------------------------------------------------
// input area byte offsets
// ------------------------------------------------------------
`define IN_LAST_ACCEPTED 2'h0
`define IN_NEXT_EXECUTED 2'h1
`define IN_STATE_CODE 2'h2
`define IN_ENTRY_COUNT 2'h3

// ------------------------------------------------------------
// entry layout (relative byte offsets inside a 4-byte entry)
// ------------------------------------------------------------
`define ENT_CONTROL 2'h0
`define ENT_SEQUENCE 2'h1
`define ENT_TIME_LO 2'h2
`define ENT_TIME_HI 2'h3
`define ENT_BYTES 8'h04
`define AREA_SMALL_ENTRIES 4'h5
`define AREA_LARGE_ENTRIES 4'hF
`define SEQ_TERM_BIT 6
`define SEQ_MASK 6'h3F
`define SEQ_FIRST 6'h01

// control byte fields
`define CTL_EN1_BIT 4
`define CTL_EN0_BIT 5
`define CTL_LVL1_BIT 6
`define CTL_LVL0_BIT 7

// ------------------------------------------------------------
// status codes and fixed bits
// ------------------------------------------------------------
`define STATE_OK 8'h00
`define STATE_NO_NEXT 8'h01
`define STATE_EMPTY 8'h02
`define STATE_FULL 8'h03
`define STATE_TERM_FLAG 8'h80
`define LAST_FIXED 2'h1
`define NEXT_FIXED 2'h3

// ------------------------------------------------------------
// storage and timing
// ------------------------------------------------------------
`define QUEUE_DEPTH 32
`define QUEUE_LIMIT 6'h1F
`define QUEUE_AW 5
`define ENTRY_W 30
// queue word packing: time low, three spare zeros, number with terminator, control nibble
`define Q_TIME_LSB 0
`define Q_TIME_W 16
`define Q_SEQ_LSB 19
`define Q_TERM_POS 25
`define Q_CTL_LSB 26
`define CTL_FIELD_LSB 4
`define SEQ_W 6
`define TICK_NS 1000
`define CLK_NS 20
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
`define TICK_DIV_MAX 6'h31

`endif

// ===== hdl/entry_fifo.v
/*
 * holds no logic: the generic entry queue store, module entry_fifo, is
 * defined in timestamped_output_fifo.v beside the scheduler that uses it.
 * assumes that file is read as part of the design.
 */

// ===== hdl/timestamped_output_fifo.v
/*
 * time-stamped two-channel output scheduler. the host writes the output
 * area as a whole image (byte writes, then a commit pulse); entries are
 * checked and queued, and applied when the low word of the microsecond
 * ticker equals their time. status is read as four bytes.
 * assumes host strobes come from logic on mclk (no synchronisers).
 * the generic entry queue store is defined at the end of this file.
 */
// How it works
// - status byte 0: last accepted number in bits 5..0, bit6=1, bit7=0
// - status byte 1: next number to execute in bits 5..0, bits 7,6 = 1
// - state code 0 right after an entry was stored
// - state code 1 when no following entry or number out of sequence
// - state code 2 after reset and when the last queued entry has been executed
// - state code 3 when full; nothing more taken while full
// - top bit of state code set while any queued entry has terminator
// - entries after one with number bit 6 set are discarded
// - status byte 3 gives current queue entry count
// - entry: control byte, number byte, two-byte microsecond time
// - control byte: bit4 en ch1, bit5 en ch0, bit6 lvl ch1, bit7 lvl ch0
// - an entry whose number is not previous plus one is refused
// - 32-bit microsecond ticker runs from power-on and wraps
// - entry time matched against ticker low 16 bits; outputs then set
// - output area is 5 or 15 entries, entry n at byte 4n
// - queue holds at most 31 accepted entries
`timescale 1ns/100ps
`include "ts_out_consts.vh"
module timestamped_output_fifo (
    input wire mclk,
    input wire arst_n,
    input wire largeArea,
    input wire outWrite,
    input wire [5:0] outAddr,
    input wire [7:0] outWData,
    input wire outCommit,
    input wire [1:0] inAddr,
    output reg [7:0] inRData,
    output reg chanLevel0,
    output reg chanLevel1,
    output reg chanEnable0,
    output reg chanEnable1,
    output reg [31:0] usTicker,
    output reg imageBusy
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function [5:0] seqInc;
        input [5:0] s;
        begin
            seqInc = (s + 6'h01) & `SEQ_MASK;
        end
    endfunction

    // ------------------------------------------------------------
    // output area image
    // ------------------------------------------------------------
    reg [7:0] image [0:63];
    reg [3:0] scanIdx;
    reg scanStop;
    reg [5:0] lastSeq;
    reg [5:0] nextSeq;
    reg [7:0] stateCode;
    reg [5:0] divCnt;
    reg usTick;
    reg [4:0] termCount;
    reg [7:0] pendCtl;
    reg [7:0] pendSeq;
    reg [15:0] pendTime;
    reg pendValid;
    wire [3:0] areaEntries;
    wire [5:0] base;
    wire fifoInReady;
    wire fifoOutValid;
    wire [`ENTRY_W-1:0] fifoOutData;
    wire [5:0] fifoLevel;
    wire qFull;
    wire pushOk;
    wire popNow;
    wire [5:0] headSeq;
    wire headTerm;

    assign areaEntries = largeArea ? `AREA_LARGE_ENTRIES : `AREA_SMALL_ENTRIES;
    assign base = {scanIdx, 2'b00};
    assign qFull = (fifoLevel >= `QUEUE_LIMIT) || !fifoInReady;
    assign pushOk = pendValid && !qFull
        && (pendSeq[5:0] == seqInc(lastSeq));
    assign headSeq = fifoOutData[`Q_SEQ_LSB +: `SEQ_W];
    assign headTerm = fifoOutData[`Q_TERM_POS];
    // the match is tried only on the tick cycle, so a head entry fires once
    assign popNow = usTick && fifoOutValid
        && (fifoOutData[`Q_TIME_LSB +: `Q_TIME_W] == usTicker[`Q_TIME_LSB +: `Q_TIME_W]);

    always @(posedge mclk) begin
        if (outWrite && !imageBusy) begin
            image[outAddr] <= outWData;
        end
    end

    // ------------------------------------------------------------
    // microsecond ticker
    // ------------------------------------------------------------
    // usTick marks the first clock of each new count, one pulse per microsecond
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            divCnt <= 6'h00;
            usTick <= 1'b0;
            usTicker <= 32'h00000000;
        end else begin
            usTick <= 1'b0;
            if (divCnt == `TICK_DIV_MAX) begin
                divCnt <= 6'h00;
                usTick <= 1'b1;
                usTicker <= usTicker + 32'h00000001;
            end else begin
                divCnt <= divCnt + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // scan of the committed image, one entry per cycle
    // ------------------------------------------------------------
    // at most one entry is pending; the next one is read as it is pushed
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            imageBusy <= 1'b0;
            scanIdx <= 4'h0;
            scanStop <= 1'b0;
            pendValid <= 1'b0;
            pendCtl <= 8'h00;
            pendSeq <= 8'h00;
            pendTime <= 16'h0000;
        end else if (!imageBusy) begin
            pendValid <= 1'b0;
            if (outCommit) begin
                imageBusy <= 1'b1;
                scanIdx <= 4'h0;
                scanStop <= 1'b0;
            end
        end else if (!pendValid || !qFull) begin
            // a full queue holds the scan; the entry stays pending
            if (scanStop || scanIdx == areaEntries) begin
                imageBusy <= 1'b0;
                pendValid <= 1'b0;
            end else begin
                pendCtl <= image[base | `ENT_CONTROL];
                pendSeq <= image[base | `ENT_SEQUENCE];
                pendTime <= {image[base | `ENT_TIME_HI], image[base | `ENT_TIME_LO]};
                pendValid <= 1'b1;
                scanStop <= image[base | `ENT_SEQUENCE][`SEQ_TERM_BIT];
                scanIdx <= scanIdx + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // sequence tracking and state code
    // ------------------------------------------------------------
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lastSeq <= 6'h00;
            nextSeq <= `SEQ_FIRST;
            stateCode <= `STATE_EMPTY;
            termCount <= 5'h00;
        end else begin
            if (pushOk) begin
                lastSeq <= pendSeq[5:0];
                stateCode <= `STATE_OK;
            end else if (pendValid && qFull) begin
                stateCode <= `STATE_FULL;
            end else if (pendValid) begin
                stateCode <= `STATE_NO_NEXT;
            end else if (popNow && fifoLevel == 6'h01) begin
                stateCode <= `STATE_EMPTY;
            end
            if (popNow) begin
                nextSeq <= seqInc(headSeq);
            end else if (!fifoOutValid) begin
                nextSeq <= seqInc(lastSeq);
            end
            if ((pushOk && pendSeq[`SEQ_TERM_BIT]) && !(popNow && headTerm)) begin
                termCount <= termCount + 5'h01;
            end else if (!(pushOk && pendSeq[`SEQ_TERM_BIT]) && popNow && headTerm) begin
                termCount <= termCount - 5'h01;
            end
        end
    end

    // one queue word: control[7:4], number[6:0], three spare zeros, time[15:0]
    entry_fifo #(
        .WIDTH(`ENTRY_W),
        .DEPTH(`QUEUE_DEPTH),
        .AW(`QUEUE_AW)
    ) queue (
        .mclk(mclk),
        .arst_n(arst_n),
        .inValid(pushOk),
        .inReady(fifoInReady),
        .inData({pendCtl[7:4], pendSeq[6:0], 3'b000, pendTime}),
        .outValid(fifoOutValid),
        .outReady(popNow),
        .outData(fifoOutData),
        .level(fifoLevel)
    );

    // ------------------------------------------------------------
    // outputs and status read-back
    // ------------------------------------------------------------
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            chanLevel0 <= 1'b0;
            chanLevel1 <= 1'b0;
            chanEnable0 <= 1'b0;
            chanEnable1 <= 1'b0;
            inRData <= 8'h00;
        end else begin
            if (popNow) begin
                chanEnable1 <= fifoOutData[`Q_CTL_LSB + `CTL_EN1_BIT - `CTL_FIELD_LSB];
                chanEnable0 <= fifoOutData[`Q_CTL_LSB + `CTL_EN0_BIT - `CTL_FIELD_LSB];
                chanLevel1 <= fifoOutData[`Q_CTL_LSB + `CTL_LVL1_BIT - `CTL_FIELD_LSB];
                chanLevel0 <= fifoOutData[`Q_CTL_LSB + `CTL_LVL0_BIT - `CTL_FIELD_LSB];
            end
            case (inAddr)
                `IN_LAST_ACCEPTED: inRData <= {`LAST_FIXED, lastSeq};
                `IN_NEXT_EXECUTED: inRData <= {`NEXT_FIXED, nextSeq};
                `IN_STATE_CODE: inRData <= stateCode
                    | ((termCount != 5'h00) ? `STATE_TERM_FLAG : 8'h00);
                `IN_ENTRY_COUNT: inRData <= {2'b00, fifoLevel};
                default: inRData <= 8'h00;
            endcase
        end
    end
endmodule

// ------------------------------------------------------------
// entry queue store
// ------------------------------------------------------------
// count is exact every cycle; the scheduler caps it one below depth,
// so inReady only guards against a cap that was set wrong
module entry_fifo #(
    parameter WIDTH = 30,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire mclk,
    input wire arst_n,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData,
    output wire [AW:0] level
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr;
    reg [AW-1:0] rdPtr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign inReady = (count != DEPTH[AW:0]);
    assign outValid = (count != {(AW+1){1'b0}});
    assign outData = mem[rdPtr];
    assign level = count;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always @(posedge mclk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// ===== dv/timestamped_output_fifo_checker.sv
/* port assertions for the scheduler.
   assumes a bind from the bench top. */
`timescale 1ns/100ps
module timestamped_output_fifo_checker (
    input wire mclk,
    input wire arst_n,
    input wire outCommit,
    input wire [1:0] inAddr,
    input wire [7:0] inRData,
    input wire [31:0] usTicker,
    input wire imageBusy
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    // ----------------
    // ticker, status and commit
    // ----------------
    chk_ticker_step: assert property (
        $changed(usTicker) |-> usTicker == $past(usTicker) + 32'h1) else $error("tick jump");
    chk_ticker_hold: assert property (
        $changed(usTicker) |=> $stable(usTicker) [*8]) else $error("tick too fast");
    chk_last_fixed: assert property (
        inAddr == 2'h0 |=> inRData[7:6] == 2'h1) else $error("byte 0 fixed bits");
    chk_next_fixed: assert property (
        inAddr == 2'h1 |=> inRData[7:6] == 2'h3) else $error("byte 1 fixed bits");
    chk_state_range: assert property (
        inAddr == 2'h2 |=> inRData[6:2] == 5'h00) else $error("bad state code");
    chk_count_limit: assert property (
        inAddr == 2'h3 |=> inRData <= 8'h1F) else $error("count over limit");
    chk_commit_busy: assert property (
        outCommit && !imageBusy |=> imageBusy) else $error("commit not taken");
    chk_busy_cause: assert property (
        $rose(imageBusy) |-> $past(outCommit)) else $error("busy without commit");
endmodule

// ===== dv/host_image_model.sv
/* host side: holds an output-area image and sends it whole.
   assumes the bench reads the status bytes itself. */
`timescale 1ns/100ps
module host_image_model (
    input wire mclk,
    input wire imageBusy,
    output reg outWrite = 1'b0,
    output reg [5:0] outAddr = 6'h00,
    output reg [7:0] outWData = 8'h00,
    output reg outCommit = 1'b0
);
    reg [7:0] img [0:59];
    integer k;
    initial for (k = 0; k < 60; k = k + 1) img[k] = 8'h00;
    task put(input [3:0] n, input [7:0] ctl, input [7:0] seq, input [15:0] t);
        img[{n, 2'h0}] = ctl;
        img[{n, 2'h1}] = seq;
        img[{n, 2'h2}] = t[7:0];
        img[{n, 2'h3}] = t[15:8];
    endtask
    // never a partial image: all bytes, then one commit
    task send(input [6:0] nb, input integer lim);
        for (k = 0; k < nb; k = k + 1) begin
            @(posedge mclk);
            outWrite <= 1'b1;
            outAddr <= k[5:0];
            outWData <= img[k];
        end
        @(posedge mclk);
        outWrite <= 1'b0;
        outWData <= ~outWData; // released data shows no stale byte
        outCommit <= 1'b1;
        @(posedge mclk);
        outCommit <= 1'b0;
        @(posedge mclk);
        repeat (lim) if (imageBusy) @(posedge mclk);
    endtask
endmodule

// ===== dv/timestamped_output_fifo_tb_top.sv
/* bench top: host model, scheduler, checker bind.
   assumes a 50 MHz clock. */
`timescale 1ns/100ps
module timestamped_output_fifo_tb_top;
    reg mclk = 1'b0;
    reg arst_n = 1'b0;
    reg largeArea = 1'b0;
    reg [1:0] inAddr = 2'h0;
    wire outWrite, outCommit, imageBusy, chanLevel0, chanLevel1, chanEnable0, chanEnable1;
    wire [5:0] outAddr;
    wire [7:0] outWData, inRData;
    wire [31:0] usTicker;
    integer mismatches = 0, n_tests = 0, cyc = 0, n, k;
    reg [15:0] t0;
    reg [7:0] s;
    host_image_model host_u (
        .mclk(mclk),
        .imageBusy(imageBusy),
        .outWrite(outWrite),
        .outAddr(outAddr),
        .outWData(outWData),
        .outCommit(outCommit)
    );
    timestamped_output_fifo dut_u (
        .mclk(mclk),
        .arst_n(arst_n),
        .largeArea(largeArea),
        .outWrite(outWrite),
        .outAddr(outAddr),
        .outWData(outWData),
        .outCommit(outCommit),
        .inAddr(inAddr),
        .inRData(inRData),
        .chanLevel0(chanLevel0),
        .chanLevel1(chanLevel1),
        .chanEnable0(chanEnable0),
        .chanEnable1(chanEnable1),
        .usTicker(usTicker),
        .imageBusy(imageBusy)
    );
    initial forever #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            close_out;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rd(input [1:0] a, input [7:0] exp);
        @(posedge mclk);
        inAddr <= a;
        @(posedge mclk);
        @(negedge mclk);
        chk(inRData, exp);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // enables first, levels later: the second entry sets both levels and keeps both enables
    task t_term;
        t0 = usTicker[15:0] + 16'd20;
        host_u.put(4'h0, 8'h30, 8'h01, t0);
        host_u.put(4'h1, 8'hF0, 8'h42, t0 + 16'd1);
        host_u.put(4'h2, 8'h00, 8'h03, t0 + 16'd2);
        host_u.send(7'd20, 200);
        rd(2'h0, 8'h42);
        rd(2'h2, 8'h80);
        rd(2'h3, 8'h02);
        repeat (2000) if (!chanEnable0) @(posedge mclk);
        chk(usTicker[15:0], t0);
        chk({chanLevel0, chanLevel1, chanEnable0, chanEnable1}, 4'h3);
        rd(2'h1, 8'hC2);
        rd(2'h3, 8'h01);
        repeat (2000) if (!chanLevel0) @(posedge mclk);
        chk(usTicker[15:0], t0 + 16'd1);
        chk({chanLevel0, chanLevel1, chanEnable0, chanEnable1}, 4'hF);
        rd(2'h2, 8'h02);
        rd(2'h3, 8'h00);
        $display("term done");
    endtask
    task t_seq;
        for (n = 0; n < 5; n = n + 1) host_u.put(n[3:0], 8'h30, 8'h05, 16'h0000);
        host_u.send(7'd20, 200);
        rd(2'h2, 8'h01);
        rd(2'h3, 8'h00);
        $display("seq done");
    endtask
    // third image stalls on a full queue until the first entry runs
    task t_full;
        @(posedge mclk);
        largeArea <= 1'b1;
        t0 = usTicker[15:0] + 16'd60;
        for (k = 0; k < 3; k = k + 1) begin
            for (n = 0; n < 15; n = n + 1) begin
                s = (k == 2 && n == 1) ? 8'h62 : 8'h03 + 8'h0F * k[7:0] + n[7:0];
                host_u.put(n[3:0], {n[0], n[0], 6'h30}, s, t0 + 16'h000F * k[15:0] + n[15:0]);
            end
            host_u.send(7'd60, k == 2 ? 20 : 400);
        end
        chk(imageBusy, 1'b1);
        rd(2'h2, 8'h03);
        rd(2'h3, 8'h1F);
        rd(2'h0, 8'h61);
        repeat (4000) if (imageBusy) @(posedge mclk);
        rd(2'h0, 8'h62);
        rd(2'h2, 8'h80);
        repeat (2000) @(posedge mclk);
        rd(2'h3, 8'h00);
        rd(2'h2, 8'h02);
        $display("full done");
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        rd(2'h0, 8'h40);
        rd(2'h1, 8'hC1);
        rd(2'h2, 8'h02);
        rd(2'h3, 8'h00);
        $display("reset done");
        t_term;
        t_seq;
        t_full;
        close_out;
    end
endmodule
bind timestamped_output_fifo timestamped_output_fifo_checker chk_u (
    .mclk(mclk),
    .arst_n(arst_n),
    .outCommit(outCommit),
    .inAddr(inAddr),
    .inRData(inRData),
    .usTicker(usTicker),
    .imageBusy(imageBusy)
);
